/* File: hw/sbm_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Strobe high: deselect, data pins released
// - Write: first data beat one cycle later
// - Read: beats delivered at n+2.5 onwards
// - Idle/write: drivers off one cycle, 2.5 later
// - Same window with termination; termination sets level
// - Lane masks sampled with each data beat
// - All masks high both beats: abort
// - Wide part: four masks gate nine-bit lanes
// - Narrow part: two masks gate nine-bit lanes
// - Second write beat on complementary edge
// - Deselect after read finishes both beats
// - Masked lane keeps stored contents
module sbm_core import sbm_pkg::*; #(
   parameter int DW = SBM_DW_DEFAULT,
   parameter int AW = SBM_AW_DEFAULT
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load_strobe_n,
   input wire logic rd_not_wr,
   input wire logic [AW-1:0] addr,
   input wire logic [DW/SBM_LANE_BITS-1:0] lane_mask_n,
   input wire logic term_on,
   input wire logic [DW-1:0] dq_in,
   output logic [DW-1:0] dq_out,
   output logic dq_oe,
   output logic dq_term_en,
   output logic k_phase,
   output logic wbuf_ready
);
   localparam int LANES = DW / SBM_LANE_BITS;
   localparam int EW = AW + 2 * LANES + 2 * DW;

   // ---------------------------------------------------------------
   // Half-period phase and command pipeline
   // ---------------------------------------------------------------
   logic phase_ff, nxt_phase;
   sbm_cmd_t kind_ff [1:SBM_PIPE_LEN];
   sbm_cmd_t nxt_kind [1:SBM_PIPE_LEN];
   logic [AW-1:0] adr_ff [1:SBM_PIPE_LEN];
   logic [AW-1:0] nxt_adr [1:SBM_PIPE_LEN];

   // Phase 0 is the primary rising edge slot, phase 1 the complementary one
   always_comb begin
      nxt_phase = ~phase_ff;
      nxt_kind[1] = SBM_CMD_IDLE;
      nxt_adr[1] = addr;
      if (!phase_ff && !load_strobe_n) begin
         nxt_kind[1] = rd_not_wr ? SBM_CMD_RD : SBM_CMD_WR;
      end
      for (int i = 2; i <= SBM_PIPE_LEN; i++) begin
         nxt_kind[i] = kind_ff[i-1];
         nxt_adr[i] = adr_ff[i-1];
      end
   end

   // Deselects travel the same pipe as reads, so they wait their turn
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_ff <= SBM_PHASE_RST;
         for (int i = 1; i <= SBM_PIPE_LEN; i++) begin
            kind_ff[i] <= SBM_CMD_IDLE;
            adr_ff[i] <= '0;
         end
      end else begin
         phase_ff <= nxt_phase;
         for (int i = 1; i <= SBM_PIPE_LEN; i++) begin
            kind_ff[i] <= nxt_kind[i];
            adr_ff[i] <= nxt_adr[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Write beat capture and buffering
   // ---------------------------------------------------------------
   logic [DW-1:0] beat1_d_ff, nxt_beat1_d;
   logic [LANES-1:0] beat1_m_ff, nxt_beat1_m;
   logic wb_in_valid;
   logic wb_in_ready;
   logic [EW-1:0] wb_in_data;
   logic wb_out_valid;
   logic [EW-1:0] wb_out_data;
   logic pop;
   logic [AW-1:0] pop_a;
   logic [LANES-1:0] pop_m1;
   logic [LANES-1:0] pop_m2;
   logic [DW-1:0] pop_d1;
   logic [DW-1:0] pop_d2;

   // First beat and its masks on the primary edge after the command
   always_comb begin
      nxt_beat1_d = beat1_d_ff;
      nxt_beat1_m = beat1_m_ff;
      if (kind_ff[SBM_WR_BEAT1_STG] == SBM_CMD_WR) begin
         nxt_beat1_d = dq_in;
         nxt_beat1_m = lane_mask_n;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         beat1_d_ff <= '0;
         beat1_m_ff <= '1;
      end else begin
         beat1_d_ff <= nxt_beat1_d;
         beat1_m_ff <= nxt_beat1_m;
      end
   end

   // Second beat joins on the complementary edge; a fully masked write is dropped
   assign wb_in_valid = (kind_ff[SBM_WR_BEAT2_STG] == SBM_CMD_WR)
      && !((&beat1_m_ff) && (&lane_mask_n));
   assign wb_in_data = {adr_ff[SBM_WR_BEAT2_STG], lane_mask_n, beat1_m_ff, dq_in, beat1_d_ff};
   assign {pop_a, pop_m2, pop_m1, pop_d2, pop_d1} = wb_out_data;
   // Drain only in phase 1 so array reads in phase 0 never collide
   assign pop = wb_out_valid & phase_ff;

   sbm_wbuf #(
      .W(EW),
      .DEPTH(SBM_WBUF_DEPTH)
   ) u_wbuf (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(wb_in_valid),
      .in_ready(wb_in_ready),
      .in_data(wb_in_data),
      .out_valid(wb_out_valid),
      .out_ready(phase_ff),
      .out_data(wb_out_data)
   );

   // ---------------------------------------------------------------
   // Memory array with per-lane write gating
   // ---------------------------------------------------------------
   logic [2*DW-1:0] mem [2**AW];

   // Each lane of each beat is written only where its mask is low
   always_ff @(posedge core_clk) begin
      if (pop) begin
         for (int l = 0; l < LANES; l++) begin
            if (!pop_m1[l]) begin
               mem[pop_a][l*SBM_LANE_BITS +: SBM_LANE_BITS] <= pop_d1[l*SBM_LANE_BITS +: SBM_LANE_BITS];
            end
            if (!pop_m2[l]) begin
               mem[pop_a][DW + l*SBM_LANE_BITS +: SBM_LANE_BITS] <=
                  pop_d2[l*SBM_LANE_BITS +: SBM_LANE_BITS];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data and driver control
   // ---------------------------------------------------------------
   logic [DW-1:0] dq_out_ff, nxt_dq_out;
   logic [DW-1:0] rd_hi_ff, nxt_rd_hi;
   logic dq_oe_ff, nxt_oe;
   logic term_en_ff, nxt_term_en;
   logic wb_ready_ff;

   // Read beats fill the slot 2.5 periods after the command; others release the pins
   always_comb begin
      nxt_dq_out = '0;
      nxt_rd_hi = rd_hi_ff;
      nxt_oe = 1'b0;
      if (kind_ff[SBM_RD_LOAD_STG] == SBM_CMD_RD) begin
         nxt_dq_out = mem[adr_ff[SBM_RD_LOAD_STG]][DW-1:0];
         nxt_rd_hi = mem[adr_ff[SBM_RD_LOAD_STG]][2*DW-1:DW];
         nxt_oe = 1'b1;
      end else if (kind_ff[SBM_RD_BEAT2_STG] == SBM_CMD_RD) begin
         nxt_dq_out = rd_hi_ff;
         nxt_oe = 1'b1;
      end
      // While released, the input termination decides the pin level
      nxt_term_en = term_on & ~nxt_oe;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dq_out_ff <= '0;
         rd_hi_ff <= '0;
         dq_oe_ff <= SBM_OE_RST;
         term_en_ff <= 1'b0;
         wb_ready_ff <= 1'b0;
      end else begin
         dq_out_ff <= nxt_dq_out;
         rd_hi_ff <= nxt_rd_hi;
         dq_oe_ff <= nxt_oe;
         term_en_ff <= nxt_term_en;
         wb_ready_ff <= wb_in_ready;
      end
   end

   assign dq_out = dq_out_ff;
   assign dq_oe = dq_oe_ff;
   assign dq_term_en = term_en_ff;
   assign k_phase = phase_ff;
   assign wbuf_ready = wb_ready_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic chk_hold_ff;
   logic chk_wr_ff;
   logic [AW-1:0] chk_a_ff;
   logic [SBM_LANE_BITS-1:0] chk_old_ff;
   logic [SBM_LANE_BITS-1:0] chk_new_ff;

   // Snapshot of lane contents around a buffered write
   always_ff @(posedge core_clk) begin
      chk_hold_ff <= !rst && pop && pop_m1[0];
      chk_wr_ff <= !rst && pop && !pop_m1[LANES-1];
      chk_a_ff <= pop_a;
      chk_old_ff <= mem[pop_a][SBM_LANE_BITS-1:0];
      chk_new_ff <= pop_d1[DW-1 -: SBM_LANE_BITS];
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_desel_off;
      (!phase_ff && load_strobe_n) |-> ##5 !dq_oe_ff ##1 !dq_oe_ff;
   endproperty
   a_desel_off: assert property (p_desel_off) else $error("deselect did not release pins");

   property p_wr_off;
      (!phase_ff && !load_strobe_n && !rd_not_wr) |-> ##5 !dq_oe_ff ##1 !dq_oe_ff;
   endproperty
   a_wr_off: assert property (p_wr_off) else $error("write did not release pins");

   property p_term;
      (!$past(rst) && $past(term_on) && !dq_oe_ff) |-> dq_term_en;
   endproperty
   a_term: assert property (p_term) else $error("termination not shown in off window");

   property p_rd_drive;
      (!phase_ff && !load_strobe_n && rd_not_wr) |-> ##5 dq_oe_ff ##1 dq_oe_ff;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read beats not driven");

   property p_rd_beat2;
      (kind_ff[SBM_RD_BEAT2_STG] == SBM_CMD_RD) |=> (dq_out_ff == $past(rd_hi_ff)) && dq_oe_ff;
   endproperty
   a_rd_beat2: assert property (p_rd_beat2) else $error("second read beat wrong");

   property p_rd_then_desel;
      (!phase_ff && !load_strobe_n && rd_not_wr) ##2 load_strobe_n |-> ##3 dq_oe_ff ##1 dq_oe_ff ##1 !dq_oe_ff;
   endproperty
   a_rd_then_desel: assert property (p_rd_then_desel) else $error("deselect cut read short");

   property p_wr_beat1;
      (!phase_ff && !load_strobe_n && !rd_not_wr) |-> ##3 (beat1_d_ff == $past(dq_in))
         && (beat1_m_ff == $past(lane_mask_n));
   endproperty
   a_wr_beat1: assert property (p_wr_beat1) else $error("first write beat not captured");

   property p_wr_beat2;
      (!phase_ff && !load_strobe_n && !rd_not_wr) ##2 !(&lane_mask_n) |-> ##1 wb_in_valid
         && (wb_in_data[2*DW-1:DW] == dq_in);
   endproperty
   a_wr_beat2: assert property (p_wr_beat2) else $error("second write beat not taken");

   property p_abort;
      (!phase_ff && !load_strobe_n && !rd_not_wr) ##2 (&lane_mask_n) ##1 (&lane_mask_n) |-> !wb_in_valid;
   endproperty
   a_abort: assert property (p_abort) else $error("aborted write was buffered");

   property p_lane_keep;
      chk_hold_ff |-> mem[chk_a_ff][SBM_LANE_BITS-1:0] == chk_old_ff;
   endproperty
   a_lane_keep: assert property (p_lane_keep) else $error("masked lane changed");

   property p_lane_write;
      chk_wr_ff |-> mem[chk_a_ff][DW-1 -: SBM_LANE_BITS] == chk_new_ff;
   endproperty
   a_lane_write: assert property (p_lane_write) else $error("unmasked lane not written");

endmodule : sbm_core
`default_nettype wire

/* File: hw/sbm_pkg.sv */
// ---------------------------------------------------------------
// Shared constants of the burst-of-two SRAM core
// ---------------------------------------------------------------
package sbm_pkg;

   // Data pins are grouped in lanes of nine bits
   localparam int SBM_LANE_BITS = 9;

   // Default widths and write buffer depth
   localparam int SBM_DW_DEFAULT = 36;
   localparam int SBM_AW_DEFAULT = 8;
   localparam int SBM_WBUF_DEPTH = 8;

   // One core_clk cycle is half a primary clock period (slot)
   localparam int SBM_CORE_PERIOD_NS = 100;
   // Driver-off delay after an idle or write command, in half periods
   localparam int SBM_DRV_OFF_HALF = 5;

   // Pipeline stage (slot after command capture) of each event
   localparam int SBM_WR_BEAT1_STG = 2;
   localparam int SBM_WR_BEAT2_STG = 3;
   localparam int SBM_RD_LOAD_STG = SBM_DRV_OFF_HALF - 1;
   localparam int SBM_RD_BEAT2_STG = SBM_DRV_OFF_HALF;
   localparam int SBM_PIPE_LEN = SBM_RD_BEAT2_STG;

   // Reset values
   localparam logic SBM_PHASE_RST = 1'b0;
   localparam logic SBM_OE_RST = 1'b0;

   // Decoded command kinds
   typedef enum logic [1:0] {
      SBM_CMD_IDLE = 2'b00,
      SBM_CMD_WR = 2'b01,
      SBM_CMD_RD = 2'b10
   } sbm_cmd_t;

endpackage : sbm_pkg

/* File: hw/sbm_wbuf.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Write buffer FIFO with valid/ready on both sides
// ---------------------------------------------------------------
module sbm_wbuf import sbm_pkg::*; #(
   parameter int W = 8,
   parameter int DEPTH = SBM_WBUF_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [PW-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [PW:0] count_ff, nxt_count;
   logic push;
   logic pop;

   // Honest full and empty from the occupancy count
   // Full is compared at the count's own width; a PW-bit cast of DEPTH would wrap to zero
   assign in_ready = (count_ff != (PW + 1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = store[rd_ptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update; pointers wrap at DEPTH
   always_comb begin
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

   // Storage needs no reset; only occupied entries are read
   always_ff @(posedge core_clk) begin
      if (push) begin
         store[wr_ptr_ff] <= in_data;
      end
   end

endmodule : sbm_wbuf
`default_nettype wire

/* File: tb/ddr_burst2_sram_command_bytemask_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench of the burst-of-two SRAM core
// ---------------------------------------------------------------
module ddr_burst2_sram_command_bytemask_tb import sbm_pkg::*;;
   localparam int DW = 36;
   localparam int NL = DW / SBM_LANE_BITS;
   localparam logic [2*DW-1:0] PAT_A = 72'hC3_5A96_0F1E_2D3C_4B5A;
   localparam logic [2*DW-1:0] PAT_B = 72'h12_3456_789A_BCDE_F012;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic term_on = 1'b0;
   logic load_strobe_n;
   logic rd_not_wr;
   logic [7:0] addr;
   logic [NL-1:0] lane_mask_n;
   logic [DW-1:0] dq_in;
   logic [DW-1:0] dq_out;
   logic dq_oe;
   logic dq_term_en;
   logic k_phase;
   logic wbuf_ready;
   // Second core built as the narrow part, two lanes per beat
   logic nar_load_strobe_n;
   logic nar_rd_not_wr;
   logic [7:0] nar_addr;
   logic [1:0] nar_lane_mask_n;
   logic [17:0] nar_dq_in;
   logic [17:0] nar_dq_out;
   logic nar_dq_oe;
   logic nar_k_phase;
   int fail_count = 0;
   int cmp_count = 0;

   always #50 core_clk = ~core_clk;

   sbm_core #(.DW(DW), .AW(8)) dut (.core_clk(core_clk), .rst(rst), .load_strobe_n(load_strobe_n),
      .rd_not_wr(rd_not_wr), .addr(addr), .lane_mask_n(lane_mask_n), .term_on(term_on), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_term_en(dq_term_en), .k_phase(k_phase), .wbuf_ready(wbuf_ready));

   sbm_ctl_model #(.DW(DW), .AW(8)) ctl (.core_clk(core_clk), .k_phase(k_phase), .dq_oe(dq_oe),
      .dq_out(dq_out), .load_strobe_n(load_strobe_n), .rd_not_wr(rd_not_wr), .addr(addr),
      .lane_mask_n(lane_mask_n), .dq_in(dq_in));

   sbm_core #(.DW(18), .AW(8)) dut_narrow (.core_clk(core_clk), .rst(rst), .load_strobe_n(nar_load_strobe_n),
      .rd_not_wr(nar_rd_not_wr), .addr(nar_addr), .lane_mask_n(nar_lane_mask_n), .term_on(term_on),
      .dq_in(nar_dq_in), .dq_out(nar_dq_out), .dq_oe(nar_dq_oe), .dq_term_en(), .k_phase(nar_k_phase),
      .wbuf_ready());

   sbm_ctl_model #(.DW(18), .AW(8)) ctl_narrow (.core_clk(core_clk), .k_phase(nar_k_phase), .dq_oe(nar_dq_oe),
      .dq_out(nar_dq_out), .load_strobe_n(nar_load_strobe_n), .rd_not_wr(nar_rd_not_wr), .addr(nar_addr),
      .lane_mask_n(nar_lane_mask_n), .dq_in(nar_dq_in));

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [2*DW-1:0] exp, input logic [2*DW-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Lanes with a low mask take the new data, the rest keep the old
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n, input logic [NL-1:0] m);
      merge = o;
      for (int l = 0; l < NL; l++) begin
         if (!m[l]) merge[l*SBM_LANE_BITS +: SBM_LANE_BITS] = n[l*SBM_LANE_BITS +: SBM_LANE_BITS];
      end
   endfunction : merge

   // Read and judge both beats; the strobe goes high right after, so a deselect follows
   task automatic rd_chk(input logic [7:0] a, input logic [2*DW-1:0] exp);
      ctl.cmd(1'b1, a);
      repeat (4) @(negedge core_clk);
      chk("oe beat1", 72'h1, 72'(dq_oe));
      chk("beat1", 72'(exp[DW-1:0]), 72'(dq_out));
      @(negedge core_clk);
      chk("oe beat2", 72'h1, 72'(dq_oe));
      chk("beat2", 72'(exp[2*DW-1:DW]), 72'(dq_out));
      @(negedge core_clk);
      chk("oe after deselect", 72'h0, 72'(dq_oe));
      chk("term after deselect", 72'(term_on), 72'(dq_term_en));
   endtask : rd_chk

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk("oe in reset", 72'h0, 72'(dq_oe));
      chk("phase in reset", 72'h0, 72'(k_phase));
      chk("ready in reset", 72'h0, 72'(wbuf_ready));
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("ready after reset", 72'h1, 72'(wbuf_ready));
      chk("oe idle", 72'h0, 72'(dq_oe));
   endtask : t_reset

   // Full write then coherent read, with termination off and on
   task automatic t_full();
      for (int t = 0; t < 2; t++) begin
         term_on = t[0];
         ctl.wr(8'h01, PAT_A ^ 72'(t), 4'h0, 4'h0);
         rd_chk(8'h01, PAT_A ^ 72'(t));
      end
      term_on = 1'b0;
   endtask : t_full

   // Every lane mask combination, inverted in the second beat
   task automatic t_lanes();
      logic [NL-1:0] m;
      for (int i = 0; i < 16; i++) begin
         m = NL'(i);
         ctl.wr(8'(8'h20 + i), PAT_A, 4'h0, 4'h0);
         ctl.wr(8'(8'h20 + i), PAT_B, m, ~m);
         rd_chk(8'(8'h20 + i), {merge(PAT_A[2*DW-1:DW], PAT_B[2*DW-1:DW], ~m),
                                merge(PAT_A[DW-1:0], PAT_B[DW-1:0], m)});
      end
   endtask : t_lanes

   // All masks high in both beats leaves the word untouched
   task automatic t_abort();
      ctl.wr(8'h40, PAT_B, 4'h0, 4'h0);
      ctl.wr(8'h40, ~PAT_B, 4'hF, 4'hF);
      rd_chk(8'h40, PAT_B);
   endtask : t_abort

   // Narrow part: beat one writes lane 0 only, beat two lane 1 only
   task automatic t_narrow();
      ctl_narrow.wr(8'h05, 36'h0, 2'b00, 2'b00);
      ctl_narrow.wr(8'h05, 36'hF_FFFF_FFFF, 2'b10, 2'b01);
      ctl_narrow.cmd(1'b1, 8'h05);
      repeat (4) @(negedge core_clk);
      chk("narrow oe beat1", 72'h1, 72'(nar_dq_oe));
      chk("narrow beat1", 72'h01FF, 72'(nar_dq_out));
      @(negedge core_clk);
      chk("narrow beat2", 72'h3_FE00, 72'(nar_dq_out));
   endtask : t_narrow

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (2) @(negedge core_clk);
      t_reset();
      t_full();
      t_lanes();
      t_abort();
      t_narrow();
      chk("ready at end", 72'h1, 72'(wbuf_ready));
      summarize();
   end

   // Whole run is under a thousand cycles; five thousand means a hang
   initial begin
      #500000;
      fail_count++;
      summarize();
   end
endmodule : ddr_burst2_sram_command_bytemask_tb
`default_nettype wire

/* File: tb/sbm_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Memory controller model on the far side of the data pins
// ---------------------------------------------------------------
module sbm_ctl_model import sbm_pkg::*; #(
   parameter int DW = SBM_DW_DEFAULT,
   parameter int AW = SBM_AW_DEFAULT
) (
   input wire logic core_clk,
   input wire logic k_phase,
   input wire logic dq_oe,
   input wire logic [DW-1:0] dq_out,
   output logic load_strobe_n,
   output logic rd_not_wr,
   output logic [AW-1:0] addr,
   output logic [DW/SBM_LANE_BITS-1:0] lane_mask_n,
   output logic [DW-1:0] dq_in
);
   logic [DW-1:0] ctl_dq = '0;
   logic [DW-1:0] last_dq = '0;
   logic [7:0] rd_hist = '0;
   logic ctl_drv;

   // Idle bus: no command, all lanes masked
   initial begin
      load_strobe_n = 1'b1;
      rd_not_wr = 1'b0;
      addr = '0;
      lane_mask_n = '1;
   end

   // Controller lets go of the pins around the read beats
   assign ctl_drv = ~|rd_hist[5:3];
   // A released pin shows the inverse of its last level, so a stale copy never passes
   assign dq_in = dq_oe ? dq_out : (ctl_drv ? ctl_dq : ~last_dq);

   // History of read commands taken, for the release window
   always @(posedge core_clk) begin
      last_dq <= dq_in;
      rd_hist <= {rd_hist[6:0], ~load_strobe_n & rd_not_wr & ~k_phase};
   end

   // Load one command in a primary-edge slot, strobe high again next slot
   task automatic cmd(input logic rd, input logic [AW-1:0] a);
      @(negedge core_clk);
      while (k_phase !== 1'b0) @(negedge core_clk);
      load_strobe_n = 1'b0;
      rd_not_wr = rd;
      addr = a;
      @(negedge core_clk);
      load_strobe_n = 1'b1;
   endtask : cmd

   // Write burst: beat one two slots after the command, beat two next slot
   task automatic wr(input logic [AW-1:0] a, input logic [2*DW-1:0] d, input logic [DW/SBM_LANE_BITS-1:0] m1,
                     input logic [DW/SBM_LANE_BITS-1:0] m2);
      cmd(1'b0, a);
      @(negedge core_clk);
      ctl_dq = d[DW-1:0];
      lane_mask_n = m1;
      @(negedge core_clk);
      ctl_dq = d[2*DW-1:DW];
      lane_mask_n = m2;
      @(negedge core_clk);
      lane_mask_n = '1;
   endtask : wr
endmodule : sbm_ctl_model
`default_nettype wire
